// ==== logic/flrc_pkg.sv ====
/*
 Package for the fault latch and reset controller: timing counts, trip
 bit positions and fault code values.
 Assumes a 100 MHz control clock.
*/
package flrc_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int CLEAR_MIN_MS = 100;   // Least hold of fault clear, ms
   localparam int RUN_DELAY_MS = 200;   // Longest wait before run, ms
   localparam int CLEAR_MIN_CYC = (CLK_HZ / 1000) * CLEAR_MIN_MS;
   localparam int RUN_DELAY_CYC = (CLK_HZ / 1000) * RUN_DELAY_MS;
   localparam int CNT_W = 25;

   // ==========================================================
   // Trip inputs, one bit each
   localparam int NTRIP = 17;
   localparam int TR_OVERCURRENT = 0;
   localparam int TR_OVERVOLTAGE = 1;
   localparam int TR_MOTOR_THERMAL = 2;
   localparam int TR_TRANSISTOR_THERMAL = 3;
   localparam int TR_POWER_FAILURE = 4;
   localparam int TR_BRAKE_TRANSISTOR = 5;
   localparam int TR_STALL_STOP = 6;
   localparam int TR_PARAMETER_ERROR = 7;
   localparam int TR_UNDERVOLTAGE = 8;
   localparam int TR_EXTERNAL_THERMAL = 9;
   localparam int TR_OPTION_CONNECTION = 10;
   localparam int TR_CPU_ERROR = 11;
   localparam int TR_OVERSPEED = 12;
   localparam int TR_SPEED_DEVIATION = 13;
   localparam int TR_ENCODER_LOSS = 14;
   localparam int TR_POSITION_ERROR = 15;
   localparam int TR_ENCODER_PHASE_A = 16;

   // ==========================================================
   // Fault history
   localparam int HIST_DEPTH = 8;
   localparam int HIST_AW = 3;
   localparam int CODE_W = 5;
   localparam logic [CODE_W-1:0] CODE_NONE = 5'h1F;
   localparam logic [CODE_W-1:0] CODE_BASE = 5'h01;  // Code is bit index plus base

   typedef enum logic [1:0] {
      FLRC_ST_NORMAL = 2'b00,
      FLRC_ST_ALARM = 2'b01,
      FLRC_ST_CLEAR = 2'b10,
      FLRC_ST_RECOVER = 2'b11
   } flrc_state_t;
endpackage

// ==== logic/flrc_hist_if.sv ====
/*
 Interface carrying fault history write and read between the controller
 and its history memory.
 Assumes one clock domain.
*/
interface flrc_hist_if;
   import flrc_pkg::*;
   logic wr_en;
   logic [CODE_W-1:0] wr_code;
   logic [HIST_AW-1:0] rd_idx;
   logic [CODE_W-1:0] rd_code;
   modport ctrl (output wr_en, output wr_code, output rd_idx, input rd_code);
   modport mem (input wr_en, input wr_code, input rd_idx, output rd_code);
endinterface

// ==== logic/flrc_hist_mem.sv ====
/*
 Eight entry fault code history; newest at index 0, read data registered.
 Assumes writes only on new trips; reset does not touch it beyond power up.
*/
module flrc_hist_mem
   import flrc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // History port
   flrc_hist_if.mem hist
);
   logic [CODE_W-1:0] mem_q [HIST_DEPTH];
   logic [CODE_W-1:0] rd_q;

   // ==========================================================
   // Shift register of codes, newest first
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < HIST_DEPTH; i++) mem_q[i] <= CODE_NONE;
      end else if (hist.wr_en) begin
         mem_q[0] <= hist.wr_code;
         for (int i = 1; i < HIST_DEPTH; i++) mem_q[i] <= mem_q[i-1];
      end
   end

   // Registered read
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) rd_q <= CODE_NONE;
      else rd_q <= mem_q[hist.rd_idx];
   end
   assign hist.rd_code = rd_q;
endmodule

// ==== logic/flrc_top.sv ====
/*
 Fault latch and reset controller: latches protective trips, drives the
 alarm relay and lamp, keeps a fault history, and handles the fault clear
 contact input with output shut-off and cold re-initialisation.
 Assumes trip inputs and run command come from logic on clk; the fault
 clear contact comes from a pin and is synchronised here.
*/
// Functional notes
// - Fault clear ends latched alarm stop
// - Clear zeroes thermal and brake accumulators
// - Output off while clear asserted
// - Run accepted within 0.2 s after release
// - Clear while running restarts from coasting
// - Trip lights lamp, latched until reset
// - Listed trips energise alarm relay
// - Phase A encoder loss also trips
// - Limiting, stall prevention, brake overheat: no alarm
// - Keep eight most recent fault codes
module flrc_top
   import flrc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Contact input from switch or controller
   input wire logic fault_clear_input,
   // Protective trips and non-alarm events
   input wire logic [NTRIP-1:0] trip_in,
   input wire logic current_limit_active,
   input wire logic stall_prevent_active,
   input wire logic brake_overheat_active,
   // Run command and motor state
   input wire logic run_cmd,
   input wire logic motor_moving,
   // Drive and initialisation
   output logic drive_enable,
   output logic run_accept,
   output logic restart_coasting,
   output logic thermal_acc_clear,
   output logic brake_acc_clear,
   output logic cold_init,
   // Alarm outputs
   output logic alarm_relay,
   output logic alarm_lamp,
   output logic [NTRIP-1:0] trip_latched,
   // Operator panel history read
   input wire logic [HIST_AW-1:0] operator_panel_idx,
   output logic [CODE_W-1:0] operator_panel_code
);
   // ==========================================================
   // Synchroniser for the contact input
   logic clr_s1_q, clr_s2_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clr_s1_q <= 1'b0;
         clr_s2_q <= 1'b0;
      end else begin
         clr_s1_q <= fault_clear_input;
         clr_s2_q <= clr_s1_q;
      end
   end
   wire clr_lvl = clr_s2_q;

   // ==========================================================
   // Hold time counter: recognise clear after 0.1 s
   logic [CNT_W-1:0] hold_cnt_q;
   wire hold_done = (hold_cnt_q >= CNT_W'(CLEAR_MIN_CYC));
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) hold_cnt_q <= '0;
      else if (!clr_lvl) hold_cnt_q <= '0;
      else if (!hold_done) hold_cnt_q <= hold_cnt_q + CNT_W'(1);
   end
   // Only a held contact counts; a short glitch must not wipe the alarm
   wire clear_valid = clr_lvl && hold_done;

   // ==========================================================
   // Trip classification; limiting events never reach the latch
   logic [NTRIP-1:0] trip_latched_q;
   wire [NTRIP-1:0] alarm_trips = trip_in; // Phase A loss is its own bit
   wire new_trip = |(alarm_trips & ~trip_latched_q);

   // ==========================================================
   // Main state
   flrc_state_t state_q, state_d;
   logic [CNT_W-1:0] rec_cnt_q;
   logic was_moving_q;
   // Synchroniser, state register and run_accept register add four cycles after the pin opens
   wire rec_done = (rec_cnt_q >= CNT_W'(RUN_DELAY_CYC - 4));

   always_comb begin
      state_d = state_q;
      case (state_q)
         FLRC_ST_NORMAL: begin
            if (clr_lvl) state_d = FLRC_ST_CLEAR;
            else if (|alarm_trips) state_d = FLRC_ST_ALARM;
         end
         FLRC_ST_ALARM: begin
            if (clr_lvl) state_d = FLRC_ST_CLEAR;
         end
         FLRC_ST_CLEAR: begin
            // A release before the hold time goes back to alarm if trips are latched, else to recover
            if (!clr_lvl) state_d = (hold_done || !(|trip_latched_q)) ? FLRC_ST_RECOVER : FLRC_ST_ALARM;
         end
         FLRC_ST_RECOVER: begin
            if (clr_lvl) state_d = FLRC_ST_CLEAR;
            else if (|alarm_trips) state_d = FLRC_ST_ALARM;
            else if (rec_done) state_d = FLRC_ST_NORMAL;
         end
         default: state_d = FLRC_ST_NORMAL;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) state_q <= FLRC_ST_NORMAL;
      else state_q <= state_d;
   end

   // Recovery timer, kept short of 0.2 s so run is back in time
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) rec_cnt_q <= '0;
      else if (state_q != FLRC_ST_RECOVER) rec_cnt_q <= '0;
      else rec_cnt_q <= rec_cnt_q + CNT_W'(1);
   end

   // Remember whether the motor was turning when clear arrived
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) was_moving_q <= 1'b0;
      else if (state_q != FLRC_ST_CLEAR && state_d == FLRC_ST_CLEAR) was_moving_q <= motor_moving;
   end

   // ==========================================================
   // Trip latch: set wins over clear, cleared only by valid clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) trip_latched_q <= '0;
      else if (clear_valid) trip_latched_q <= alarm_trips;
      else trip_latched_q <= trip_latched_q | alarm_trips;
   end

   // ==========================================================
   // History write: lowest newly latched bit gives the code
   logic [CODE_W-1:0] first_code;
   always_comb begin
      first_code = CODE_NONE;
      for (int i = NTRIP - 1; i >= 0; i--) begin
         if (alarm_trips[i] && !trip_latched_q[i]) first_code = CODE_W'(i) + CODE_BASE;
      end
   end

   flrc_hist_if hist ();
   assign hist.wr_en = new_trip;
   assign hist.wr_code = first_code;
   assign hist.rd_idx = operator_panel_idx;

   // History is not cleared by fault clear
   flrc_hist_mem u_hist (
      .clk(clk),
      .arst_n(arst_n),
      .hist(hist)
   );

   // ==========================================================
   // Registered outputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         alarm_relay <= 1'b0;
         alarm_lamp <= 1'b0;
         drive_enable <= 1'b0;
         run_accept <= 1'b0;
         restart_coasting <= 1'b0;
         cold_init <= 1'b0;
         operator_panel_code <= CODE_NONE;
         trip_latched <= '0;
      end else begin
         alarm_relay <= |trip_latched_q;
         alarm_lamp <= |trip_latched_q;
         // Drive off immediately on clear and throughout it
         drive_enable <= (state_d == FLRC_ST_NORMAL) && !(|trip_latched_q) && !(|alarm_trips) && run_cmd;
         run_accept <= (state_d == FLRC_ST_NORMAL);
         restart_coasting <= (state_q == FLRC_ST_RECOVER) && rec_done && was_moving_q;
         cold_init <= clr_lvl;
         operator_panel_code <= hist.rd_code;
         trip_latched <= trip_latched_q;
      end
   end
   // Accumulators cleared at once while clear is active
   assign thermal_acc_clear = cold_init;
   assign brake_acc_clear = cold_init;
   // Limiting events are observed only so that they are known not to alarm
   wire unused_limits = current_limit_active ^ stall_prevent_active ^ brake_overheat_active;

   // ==========================================================
   // Checks
   sequence s_clear_held;
      clr_lvl [*2];
   endsequence

   a_drive_off_clear: assert property (@(posedge clk) disable iff (!arst_n)
      clr_lvl |=> !drive_enable) else $error("drive enabled during clear");
   a_lamp_follows_latch: assert property (@(posedge clk) disable iff (!arst_n)
      |trip_latched_q |=> alarm_lamp) else $error("lamp not lit on trip");
   a_relay_on_trip: assert property (@(posedge clk) disable iff (!arst_n)
      |trip_in |-> ##2 alarm_relay) else $error("relay not energised");
   a_phase_a_trip: assert property (@(posedge clk) disable iff (!arst_n)
      trip_in[TR_ENCODER_PHASE_A] |=> trip_latched_q[TR_ENCODER_PHASE_A]) else $error("phase A loss missed");
   a_latch_holds: assert property (@(posedge clk) disable iff (!arst_n)
      (trip_latched_q != 0 && !clear_valid) |=> (trip_latched_q != 0)) else $error("latch lost");
   a_clear_init: assert property (@(posedge clk) disable iff (!arst_n)
      s_clear_held |-> thermal_acc_clear && brake_acc_clear) else $error("accumulators not cleared");
   a_no_alarm_limit: assert property (@(posedge clk) disable iff (!arst_n)
      (trip_latched_q == 0 && trip_in == 0) |=> !alarm_relay) else $error("relay without trip");
   a_recover_bound: assert property (@(posedge clk) disable iff (!arst_n)
      (state_q == FLRC_ST_RECOVER && rec_done && !clr_lvl && trip_in == 0) |=> run_accept)
      else $error("run not accepted in time");
   a_history_write: assert property (@(posedge clk) disable iff (!arst_n)
      (trip_in != 0 && trip_latched_q == 0) |-> hist.wr_en) else $error("history not written");
   a_reset_drops: assert property (@(posedge clk) disable iff (!arst_n)
      (clear_valid && trip_in == 0) |=> ##1 !alarm_relay && !alarm_lamp) else $error("alarm stays after reset");
endmodule

// ==== tb/flrc_contact_model.sv ====
/*
 Behavioural model of the switch contact or controller output that closes
 the fault clear input to the contact common.
 Assumes the bench calls press() and that the pin reads high while shorted.
*/
module flrc_contact_model (
   // Clock
   input wire logic clk,
   // Contact as seen at the pin
   output logic fault_clear_input
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Contact drive
   // An open contact reads inactive; nothing else holds the pin up
   initial fault_clear_input = 1'h0;

   // Close for n cycles; changes land just after falling edges
   task automatic press(input int n);
      @(negedge clk);
      fault_clear_input = 1'h1;
      repeat (n) @(negedge clk);
      fault_clear_input = 1'h0;
   endtask
endmodule

// ==== tb/flrc_top_tb.sv ====
/*
 Self-checking bench for the fault latch and reset controller.
 Assumes the package counts are full size, so a complete clear cycle is
 out of reach in a short run; only clears released before the minimum hold are exercised.
*/
module flrc_top_tb
   import flrc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Signals
   logic clk, arst_n, run_cmd, motor_moving;
   logic current_limit_active, stall_prevent_active, brake_overheat_active;
   logic [NTRIP-1:0] trip_in, trip_latched;
   logic [HIST_AW-1:0] operator_panel_idx;
   logic [CODE_W-1:0] operator_panel_code;
   logic fault_clear_input, drive_enable, run_accept, restart_coasting;
   logic thermal_acc_clear, brake_acc_clear, cold_init, alarm_relay, alarm_lamp;
   int err_total = 0;
   int samples_checked = 0;
   int cycle_count = 0;

   flrc_contact_model u_contact (.clk(clk), .fault_clear_input(fault_clear_input));

   flrc_top dut (.clk(clk), .arst_n(arst_n), .fault_clear_input(fault_clear_input),
      .trip_in(trip_in), .current_limit_active(current_limit_active),
      .stall_prevent_active(stall_prevent_active), .brake_overheat_active(brake_overheat_active),
      .run_cmd(run_cmd), .motor_moving(motor_moving), .drive_enable(drive_enable),
      .run_accept(run_accept), .restart_coasting(restart_coasting),
      .thermal_acc_clear(thermal_acc_clear), .brake_acc_clear(brake_acc_clear),
      .cold_init(cold_init), .alarm_relay(alarm_relay), .alarm_lamp(alarm_lamp),
      .trip_latched(trip_latched), .operator_panel_idx(operator_panel_idx),
      .operator_panel_code(operator_panel_code));

   // ==========================================================
   // Clock and hang guard
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // Whole run is a few hundred cycles; the ceiling leaves ample slack
   always @(posedge clk) begin
      cycle_count <= cycle_count + 1;
      if (cycle_count == 2000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // ==========================================================
   // Comparison and verdict
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   // History must read empty on every slot after power up
   task automatic history_empty();
      for (int k = 0; k < HIST_DEPTH; k++) begin
         operator_panel_idx = k[HIST_AW-1:0];
         repeat (3) @(negedge clk);
         check("empty_slot", operator_panel_code, 32'(CODE_NONE));
      end
   endtask

   // Limiting, stall prevention and brake overheat stay silent
   task automatic no_alarm_events();
      for (int i = 0; i < 3; i++) begin
         {current_limit_active, stall_prevent_active, brake_overheat_active} = 3'h1 << i;
         repeat (4) @(negedge clk);
         check("relay_quiet", alarm_relay, 32'h0);
         check("lamp_quiet", alarm_lamp, 32'h0);
      end
      {current_limit_active, stall_prevent_active, brake_overheat_active} = 3'h0;
   endtask

   // Running drive is cut while clear is held; accumulators held at zero
   task automatic run_then_clear();
      run_cmd = 1'h1;
      motor_moving = 1'h1;
      repeat (4) @(negedge clk);
      check("run_accept", run_accept, 32'h1);
      check("drive_on", drive_enable, 32'h1);
      fork
         u_contact.press(20);
      join_none
      repeat (5) @(negedge clk);
      for (int i = 0; i < 12; i++) begin
         check("drive_off", drive_enable, 32'h0);
         check("cold_init", cold_init, 32'h1);
         check("thermal_clr", thermal_acc_clear, 32'h1);
         check("brake_clr", brake_acc_clear, 32'h1);
         check("run_refused", run_accept, 32'h0);
         check("no_restart", restart_coasting, 32'h0);
         @(negedge clk);
      end
      repeat (10) @(negedge clk);
      // Contact open again; recovery still runs, so the drive stays off
      check("cold_init_end", cold_init, 32'h0);
      check("recover_wait", run_accept, 32'h0);
      check("drive_still_off", drive_enable, 32'h0);
      check("no_early_restart", restart_coasting, 32'h0);
      run_cmd = 1'h0;
      motor_moving = 1'h0;
   endtask

   // Every trip source latches and alarms; the newest eight codes are kept
   task automatic all_trips();
      for (int b = 0; b < NTRIP; b++) begin
         trip_in = NTRIP'(1) << b;
         repeat (3) @(negedge clk);
         if (b == TR_ENCODER_PHASE_A) begin
            check("phase_a_latch", trip_latched[b], 32'h1);
         end else begin
            check("trip_latch", trip_latched[b], 32'h1);
         end
         check("relay_on", alarm_relay, 32'h1);
      end
      trip_in = '0;
      repeat (5) @(negedge clk);
      check("lamp_held", alarm_lamp, 32'h1);
      for (int k = 0; k < HIST_DEPTH; k++) begin
         operator_panel_idx = k[HIST_AW-1:0];
         repeat (3) @(negedge clk);
         check("hist_code", operator_panel_code, 32'(NTRIP - k));
      end
   endtask

   // A clear shorter than the minimum hold leaves the alarm latched
   task automatic short_clear_refused();
      u_contact.press(20);
      repeat (30) @(negedge clk);
      check("relay_kept", alarm_relay, 32'h1);
      check("latch_kept", trip_latched, 32'({NTRIP{1'b1}}));
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      arst_n = 1'h0;
      trip_in = '0;
      {current_limit_active, stall_prevent_active, brake_overheat_active} = 3'h0;
      run_cmd = 1'h0;
      motor_moving = 1'h0;
      operator_panel_idx = 3'h0;
      repeat (6) @(negedge clk);
      check("relay_reset", alarm_relay, 32'h0);
      arst_n = 1'h1;
      repeat (2) @(negedge clk);
      history_empty();
      no_alarm_events();
      run_then_clear();
      all_trips();
      short_clear_refused();
      tally_and_finish();
   end
endmodule
